// ---- flcp_pkg.sv ----
package flcp_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_ENA        = 9'h171;
  localparam logic [8:0] IDX_INT        = 9'h172;
  localparam logic [8:0] IDX_NUM        = 9'h173;
  localparam logic [8:0] IDX_DEN        = 9'h174;
  localparam logic [8:0] IDX_RATIO      = 9'h175;
  localparam logic [8:0] IDX_REFDIV     = 9'h176;
  localparam logic [8:0] IDX_SYNC_ENA   = 9'h181;
  localparam logic [8:0] IDX_SYNC_INT   = 9'h182;
  localparam logic [8:0] IDX_SYNC_NUM   = 9'h183;
  localparam logic [8:0] IDX_SYNC_DEN   = 9'h184;
  localparam logic [8:0] IDX_SYNC_RATIO = 9'h185;
  localparam logic [8:0] IDX_SYNC_DIV   = 9'h186;
  localparam logic [8:0] IDX_SYNC_GAIN  = 9'h187;

  // Field positions and widths
  localparam int ENA_BIT        = 0;
  localparam int UPD_BIT        = 15;
  localparam int INT_W          = 10;
  localparam int FRAC_W         = 16;
  localparam int RATIO_LSB      = 8;
  localparam int RATIO_W        = 4;
  localparam int OUTDIV_LSB     = 1;
  localparam int OUTDIV_W       = 3;
  localparam int REFDIV_LSB     = 6;
  localparam int REFDIV_W       = 2;
  localparam int SRATIO_LSB     = 8;
  localparam int SRATIO_W       = 3;
  localparam int GAIN_LSB       = 2;
  localparam int GAIN_W         = 4;
  localparam int BW_BIT         = 0;
  localparam int LRATIO_W       = 5;
  localparam int PRATIO_W       = 4;

  // Reset values
  localparam logic [INT_W-1:0]    RST_INT    = 10'h008;
  localparam logic [FRAC_W-1:0]   RST_NUM    = 16'h0018;
  localparam logic [FRAC_W-1:0]   RST_DEN    = 16'h007d;
  localparam logic [RATIO_W-1:0]  RST_RATIO  = 4'h0;
  localparam logic [OUTDIV_W-1:0] RST_OUTDIV = 3'h3;
  localparam logic [REFDIV_W-1:0] RST_REFDIV = 2'h0;
  localparam logic                RST_BW     = 1'b1;

  // Code limits
  localparam logic [OUTDIV_W-1:0] OUTDIV_MIN  = 3'h2;
  localparam logic [SRATIO_W-1:0] SRATIO_TOP  = 3'h4;

  // Loop configuration carried as one word
  typedef struct packed {
    logic [RATIO_W-1:0]  ratio;
    logic [OUTDIV_W-1:0] outdiv;
    logic [REFDIV_W-1:0] refdiv;
    logic [SRATIO_W-1:0] sratio;
    logic [REFDIV_W-1:0] sdiv;
    logic [GAIN_W-1:0]   sgain;
    logic                sbw;
  } flcp_cfg_t;

endpackage

// ---- flcp_tickdiv.sv ----
`timescale 1ns/1ps
// Divides a stream of single-cycle ticks by a run-time ratio
module flcp_tickdiv
  import flcp_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_ratio,
  output logic              o_tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } flcp_tdiv_t;

  flcp_tdiv_t s_q;
  flcp_tdiv_t s_d;

  // Count input ticks, emit one per ratio
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (i_tick) begin
      if (s_q.cnt >= i_ratio - W'(1)) begin
        s_d.cnt  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule

// ---- flcp_outdiv.sv ----
`timescale 1ns/1ps
// Output divider on oscillator ticks; reserved codes stop the output
module flcp_outdiv
  import flcp_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_run,
  input  wire logic                i_tick,
  input  wire logic [OUTDIV_W-1:0] i_code,
  output logic                     o_tick
);

  typedef struct packed {
    logic [OUTDIV_W-1:0] cnt;
    logic                tick;
  } flcp_odiv_t;

  flcp_odiv_t s_q;
  flcp_odiv_t s_d;

  // Codes below the minimum are reserved: no output at all
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!i_run || i_code < OUTDIV_MIN) begin
      s_d.cnt = '0;
    end else if (i_tick) begin
      if (s_q.cnt >= i_code - OUTDIV_W'(1)) begin
        s_d.cnt  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + OUTDIV_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule

// ---- flcp_top.sv ----
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module flcp_top
  import flcp_pkg::*;
(
  input  wire logic                I_CLK,
  input  wire logic                I_RST,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [ADDR_W-1:0]   PADDR,
  input  wire logic [DATA_W-1:0]   PWDATA,
  output logic      [DATA_W-1:0]   PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic                I_REF_TICK,
  input  wire logic                I_SYNC_TICK,
  input  wire logic                I_VCO_TICK,
  output logic                     O_LOOP_ENABLE,
  output logic                     O_SYNC_ENABLE,
  output logic      [INT_W-1:0]    O_MULT_INT,
  output logic      [FRAC_W-1:0]   O_FRAC_NUM,
  output logic      [FRAC_W-1:0]   O_FRAC_DEN,
  output logic                     O_FRAC_SCALED,
  output logic      [LRATIO_W-1:0] O_LOOP_RATIO,
  output logic      [OUTDIV_W-1:0] O_OUTDIV_RATIO,
  output logic      [PRATIO_W-1:0] O_REF_RATIO,
  output logic      [LRATIO_W-1:0] O_SYNC_RATIO,
  output logic      [INT_W-1:0]    O_SYNC_INT,
  output logic      [FRAC_W-1:0]   O_SYNC_NUM,
  output logic      [FRAC_W-1:0]   O_SYNC_DEN,
  output logic      [GAIN_W-1:0]   O_SYNC_GAIN,
  output logic                     O_SYNC_NARROW,
  output logic                     O_REF_TICK,
  output logic                     O_SYNC_TICK,
  output logic                     O_OUT_TICK
);

  typedef struct packed {
    logic                ena;
    logic [INT_W-1:0]    n_pend;
    logic [INT_W-1:0]    n_act;
    logic [FRAC_W-1:0]   th_pend;
    logic [FRAC_W-1:0]   th_act;
    logic [FRAC_W-1:0]   lam;
    flcp_cfg_t           cfg;
    logic                sena;
    logic [INT_W-1:0]    sn;
    logic [FRAC_W-1:0]   sth;
    logic [FRAC_W-1:0]   slam;
    logic [FRAC_W-1:0]   den_out;
    logic                scaled;
    logic [LRATIO_W-1:0] lratio;
    logic [OUTDIV_W-1:0] odiv;
    logic [PRATIO_W-1:0] rratio;
    logic [LRATIO_W-1:0] sratio;
    logic [DATA_W-1:0]   rdata;
    logic                ready;
    logic                err;
  } flcp_state_t;

  flcp_state_t s_q;
  flcp_state_t s_d;

  // Word address match against a register index
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [8:0] idx);
    return a[ADDR_W-1:2] == {1'b0, idx};
  endfunction

  // Power-of-two divider coding shared by both reference paths
  function automatic logic [PRATIO_W-1:0] pow2(
      input logic [REFDIV_W-1:0] c);
    return PRATIO_W'(1) << c;
  endfunction

  // Address is mapped at all
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, IDX_ENA) || hit(a, IDX_INT) || hit(a, IDX_NUM) ||
           hit(a, IDX_DEN) || hit(a, IDX_RATIO) || hit(a, IDX_REFDIV) ||
           hit(a, IDX_SYNC_ENA) || hit(a, IDX_SYNC_INT) ||
           hit(a, IDX_SYNC_NUM) || hit(a, IDX_SYNC_DEN) ||
           hit(a, IDX_SYNC_RATIO) || hit(a, IDX_SYNC_DIV) ||
           hit(a, IDX_SYNC_GAIN);
  endfunction

  logic             acc_first;
  logic             wr_fire;
  logic             upd_req;
  logic [DATA_W-1:0] rd_mux;

  // Access phase: one wait state, commit on the second access edge
  assign acc_first = PSEL && PENABLE && !s_q.ready;
  assign wr_fire   = PSEL && PENABLE && s_q.ready && PWRITE;
  assign upd_req   = wr_fire && hit(PADDR, IDX_INT) && PWDATA[UPD_BIT];

  // Read view; pending multiplier values are what software sees
  always_comb begin
    rd_mux = '0;
    if (hit(PADDR, IDX_ENA)) begin
      rd_mux[ENA_BIT] = s_q.ena;
    end else if (hit(PADDR, IDX_INT)) begin
      rd_mux[INT_W-1:0] = s_q.n_pend;
    end else if (hit(PADDR, IDX_NUM)) begin
      rd_mux[FRAC_W-1:0] = s_q.th_pend;
    end else if (hit(PADDR, IDX_DEN)) begin
      rd_mux[FRAC_W-1:0] = s_q.lam;
    end else if (hit(PADDR, IDX_RATIO)) begin
      rd_mux[RATIO_LSB +: RATIO_W]   = s_q.cfg.ratio;
      rd_mux[OUTDIV_LSB +: OUTDIV_W] = s_q.cfg.outdiv;
    end else if (hit(PADDR, IDX_REFDIV)) begin
      rd_mux[REFDIV_LSB +: REFDIV_W] = s_q.cfg.refdiv;
    end else if (hit(PADDR, IDX_SYNC_ENA)) begin
      rd_mux[ENA_BIT] = s_q.sena;
    end else if (hit(PADDR, IDX_SYNC_INT)) begin
      rd_mux[INT_W-1:0] = s_q.sn;
    end else if (hit(PADDR, IDX_SYNC_NUM)) begin
      rd_mux[FRAC_W-1:0] = s_q.sth;
    end else if (hit(PADDR, IDX_SYNC_DEN)) begin
      rd_mux[FRAC_W-1:0] = s_q.slam;
    end else if (hit(PADDR, IDX_SYNC_RATIO)) begin
      rd_mux[SRATIO_LSB +: SRATIO_W] = s_q.cfg.sratio;
    end else if (hit(PADDR, IDX_SYNC_DIV)) begin
      rd_mux[REFDIV_LSB +: REFDIV_W] = s_q.cfg.sdiv;
    end else if (hit(PADDR, IDX_SYNC_GAIN)) begin
      rd_mux[GAIN_LSB +: GAIN_W] = s_q.cfg.sgain;
      rd_mux[BW_BIT]             = s_q.cfg.sbw;
    end
  end

  // Register file and staged multiplier update
  always_comb begin
    s_d = s_q;
    s_d.ready = acc_first;
    if (acc_first) begin
      s_d.rdata = PWRITE ? '0 : rd_mux;
      s_d.err   = !mapped(PADDR);
    end
    if (wr_fire) begin
      if (hit(PADDR, IDX_ENA)) begin
        s_d.ena = PWDATA[ENA_BIT];
      end
      if (hit(PADDR, IDX_INT)) begin
        s_d.n_pend = PWDATA[INT_W-1:0];
        if (!s_q.ena) begin
          s_d.n_act = PWDATA[INT_W-1:0];
        end
      end
      if (hit(PADDR, IDX_NUM)) begin
        s_d.th_pend = PWDATA[FRAC_W-1:0];
        if (!s_q.ena) begin
          s_d.th_act = PWDATA[FRAC_W-1:0];
        end
      end
      if (hit(PADDR, IDX_DEN)) begin
        s_d.lam = PWDATA[FRAC_W-1:0];
      end
      if (hit(PADDR, IDX_RATIO)) begin
        s_d.cfg.ratio  = PWDATA[RATIO_LSB +: RATIO_W];
        s_d.cfg.outdiv = PWDATA[OUTDIV_LSB +: OUTDIV_W];
      end
      if (hit(PADDR, IDX_REFDIV)) begin
        s_d.cfg.refdiv = PWDATA[REFDIV_LSB +: REFDIV_W];
      end
      if (hit(PADDR, IDX_SYNC_ENA)) begin
        s_d.sena = PWDATA[ENA_BIT];
      end
      if (hit(PADDR, IDX_SYNC_INT)) begin
        s_d.sn = PWDATA[INT_W-1:0];
      end
      if (hit(PADDR, IDX_SYNC_NUM)) begin
        s_d.sth = PWDATA[FRAC_W-1:0];
      end
      if (hit(PADDR, IDX_SYNC_DEN)) begin
        s_d.slam = PWDATA[FRAC_W-1:0];
      end
      if (hit(PADDR, IDX_SYNC_RATIO)) begin
        s_d.cfg.sratio = PWDATA[SRATIO_LSB +: SRATIO_W];
      end
      if (hit(PADDR, IDX_SYNC_DIV)) begin
        s_d.cfg.sdiv = PWDATA[REFDIV_LSB +: REFDIV_W];
      end
      if (hit(PADDR, IDX_SYNC_GAIN)) begin
        s_d.cfg.sgain = PWDATA[GAIN_LSB +: GAIN_W];
        s_d.cfg.sbw   = PWDATA[BW_BIT];
      end
    end
    // Both fields move together, so the loop never sees a torn pair
    if (upd_req && s_q.ena) begin
      s_d.n_act  = PWDATA[INT_W-1:0];
      s_d.th_act = s_q.th_pend;
    end
    // Decoded view of the live configuration, one cycle behind
    s_d.lratio = LRATIO_W'(s_q.cfg.ratio) + LRATIO_W'(1);
    s_d.odiv   = (s_q.cfg.outdiv < OUTDIV_MIN) ? '0 : s_q.cfg.outdiv;
    s_d.rratio = pow2(s_q.cfg.refdiv);
    // Codes 1XX all mean the top ratio
    if (s_q.cfg.sratio >= SRATIO_TOP) begin
      s_d.sratio = LRATIO_W'(1) << SRATIO_TOP;
    end else begin
      s_d.sratio = LRATIO_W'(1) << s_q.cfg.sratio;
    end
    // Denominator has no meaning once the numerator is K scaled
    s_d.scaled  = s_q.sena;
    s_d.den_out = s_q.sena ? '0 : s_q.lam;
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_q         <= '0;
      s_q.n_pend  <= RST_INT;
      s_q.n_act   <= RST_INT;
      s_q.th_pend <= RST_NUM;
      s_q.th_act  <= RST_NUM;
      s_q.lam     <= RST_DEN;
      s_q.den_out <= RST_DEN;
      s_q.cfg.ratio  <= RST_RATIO;
      s_q.cfg.outdiv <= RST_OUTDIV;
      s_q.cfg.refdiv <= RST_REFDIV;
      s_q.cfg.sbw    <= RST_BW;
      s_q.lratio  <= LRATIO_W'(1);
      s_q.odiv    <= RST_OUTDIV;
      s_q.rratio  <= PRATIO_W'(1);
      s_q.sratio  <= LRATIO_W'(1);
    end else begin
      s_q <= s_d;
    end
  end

  // Reference paths; both dividers free-run so ratios settle early
  flcp_tickdiv #(.W(PRATIO_W)) u_refdiv (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_tick  (I_REF_TICK),
    .i_ratio (s_q.rratio),
    .o_tick  (O_REF_TICK)
  );

  flcp_tickdiv #(.W(PRATIO_W)) u_syncdiv (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_tick  (I_SYNC_TICK),
    .i_ratio (pow2(s_q.cfg.sdiv)),
    .o_tick  (O_SYNC_TICK)
  );

  // Output clock only while the loop runs
  flcp_outdiv u_outdiv (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_run  (s_q.ena),
    .i_tick (I_VCO_TICK),
    .i_code (s_q.cfg.outdiv),
    .o_tick (O_OUT_TICK)
  );

  assign PRDATA         = s_q.rdata;
  assign PREADY         = s_q.ready;
  assign PSLVERR        = s_q.err;
  assign O_LOOP_ENABLE  = s_q.ena;
  assign O_SYNC_ENABLE  = s_q.sena;
  assign O_MULT_INT     = s_q.n_act;
  assign O_FRAC_NUM     = s_q.th_act;
  assign O_FRAC_DEN     = s_q.den_out;
  assign O_FRAC_SCALED  = s_q.scaled;
  assign O_LOOP_RATIO   = s_q.lratio;
  assign O_OUTDIV_RATIO = s_q.odiv;
  assign O_REF_RATIO    = s_q.rratio;
  assign O_SYNC_RATIO   = s_q.sratio;
  assign O_SYNC_INT     = s_q.sn;
  assign O_SYNC_NUM     = s_q.sth;
  assign O_SYNC_DEN     = s_q.slam;
  assign O_SYNC_GAIN    = s_q.cfg.sgain;
  assign O_SYNC_NARROW  = s_q.cfg.sbw;

  // Checks on the configuration path
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  logic wr_int;
  logic wr_num;
  assign wr_int = wr_fire && hit(PADDR, IDX_INT);
  assign wr_num = wr_fire && hit(PADDR, IDX_NUM);

  upd_apply_a: assert property (upd_req && s_q.ena |=>
    O_MULT_INT == $past(PWDATA[INT_W-1:0]) &&
    O_FRAC_NUM == $past(s_q.th_pend))
    else $error("update write did not apply pending pair");

  pend_hold_a: assert property (wr_num && s_q.ena && !upd_req |=>
    $stable(O_FRAC_NUM))
    else $error("numerator changed without update");

  direct_int_a: assert property (wr_int && !s_q.ena |=>
    O_MULT_INT == $past(PWDATA[INT_W-1:0]))
    else $error("integer write not direct while disabled");

  direct_num_a: assert property (wr_num && !s_q.ena |=>
    O_FRAC_NUM == $past(PWDATA[FRAC_W-1:0]))
    else $error("numerator write not direct while disabled");

  loop_ratio_a: assert property (##1 O_LOOP_RATIO ==
    LRATIO_W'($past(s_q.cfg.ratio)) + LRATIO_W'(1))
    else $error("loop ratio not code plus one");

  out_res_a: assert property (s_q.cfg.outdiv < OUTDIV_MIN |->
    ##2 !O_OUT_TICK)
    else $error("output ticks with reserved divider");

  ref_ratio_a: assert property (##1 O_REF_RATIO ==
    PRATIO_W'(1) << $past(s_q.cfg.refdiv))
    else $error("reference ratio wrong");

  sync_ratio_a: assert property (s_q.cfg.sratio[SRATIO_W-1] |=>
    O_SYNC_RATIO == (LRATIO_W'(1) << SRATIO_TOP))
    else $error("sync ratio top code wrong");

  den_ignore_a: assert property (s_q.sena |=>
    O_FRAC_SCALED && O_FRAC_DEN == '0)
    else $error("denominator visible in scaled mode");

  int_width_a: assert property (acc_first && !PWRITE &&
    hit(PADDR, IDX_INT) |=> PRDATA[DATA_W-1:INT_W] == '0)
    else $error("integer read has high bits set");

  apb_wait_a: assert property (acc_first |=> PREADY ##1 !PREADY)
    else $error("answer not one cycle wide");

  upd_cov_c: cover property (upd_req && s_q.ena);
  direct_cov_c: cover property (wr_int && !s_q.ena);
  scaled_cov_c: cover property (s_q.sena && s_q.ena);
  outtick_cov_c: cover property (O_OUT_TICK);

endmodule

// ---- flcp_clk_src.sv ----
`timescale 1ns/1ps
// Far-side sources as single-cycle ticks on the core clock
module flcp_clk_src
  import flcp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic [7:0] i_num,
  output logic            o_ref_tick,
  output logic            o_sync_tick,
  output logic            o_vco_tick,
  output logic            o_busy
);
  // Reference, synchroniser and oscillator tick spacing in core cycles
  localparam int PER [3] = '{3, 5, 2};
  logic [7:0] left [3];
  logic [2:0] ph   [3];
  logic [2:0] tick;

  // Bursts of i_num ticks; sources stand still between bursts
  always_ff @(posedge i_clk or posedge i_rst) begin
    for (int k = 0; k < 3; k++) begin
      if (i_rst) begin
        left[k] <= '0;
        ph[k] <= '0;
        tick[k] <= 1'b0;
      end else begin
        tick[k] <= 1'b0;
        if (i_start) begin
          left[k] <= i_num;
          ph[k] <= '0;
        end else if (left[k] != 8'h00) begin
          if (ph[k] == 3'(PER[k] - 1)) begin
            tick[k] <= 1'b1;
            left[k] <= left[k] - 8'h01;
            ph[k] <= '0;
          end else begin
            ph[k] <= ph[k] + 3'h1;
          end
        end
      end
    end
  end

  // Busy until every source has sent its burst
  assign o_busy      = (left[0] | left[1] | left[2]) != 8'h00;
  assign o_ref_tick  = tick[0];
  assign o_sync_tick = tick[1];
  assign o_vco_tick  = tick[2];
endmodule

// ---- tb_freq_loop_param_config.sv ----
`timescale 1ns/1ps
module tb_freq_loop_param_config;
  import flcp_pkg::*;

  typedef struct {
    logic [8:0]  idx;
    logic [31:0] wd;
    logic [31:0] rd;
    int          sel;
    logic [31:0] exp;
  } flcp_row_t;

  logic                clk     = 1'b0;
  logic                rst     = 1'b1;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [ADDR_W-1:0]   paddr   = '0;
  logic [DATA_W-1:0]   pwdata  = '0;
  logic                start   = 1'b0;
  logic [7:0]          num     = '0;
  logic [DATA_W-1:0]   prdata, rdv;
  logic                pready, pslverr, err, busy, ref_t, sync_t, vco_t;
  logic                loop_en, sync_en, scaled, narrow, ref_o, sync_o, out_o;
  logic [INT_W-1:0]    mult, sint;
  logic [FRAC_W-1:0]   fnum, fden, snum, sden;
  logic [LRATIO_W-1:0] lratio, sratio;
  logic [OUTDIV_W-1:0] oratio;
  logic [PRATIO_W-1:0] rratio;
  logic [GAIN_W-1:0]   sgain;
  int                  errors = 0, num_checks = 0;
  int                  n_ref = 0, n_sync = 0, n_out = 0;
  flcp_row_t           rows [$];

  always #50 clk = ~clk;

  flcp_top dut_u (
    .I_CLK(clk), .I_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .I_REF_TICK(ref_t),
    .I_SYNC_TICK(sync_t), .I_VCO_TICK(vco_t), .O_LOOP_ENABLE(loop_en),
    .O_SYNC_ENABLE(sync_en), .O_MULT_INT(mult), .O_FRAC_NUM(fnum),
    .O_FRAC_DEN(fden), .O_FRAC_SCALED(scaled), .O_LOOP_RATIO(lratio),
    .O_OUTDIV_RATIO(oratio), .O_REF_RATIO(rratio),
    .O_SYNC_RATIO(sratio), .O_SYNC_INT(sint), .O_SYNC_NUM(snum),
    .O_SYNC_DEN(sden), .O_SYNC_GAIN(sgain), .O_SYNC_NARROW(narrow),
    .O_REF_TICK(ref_o), .O_SYNC_TICK(sync_o), .O_OUT_TICK(out_o)
  );

  flcp_clk_src src_u (
    .i_clk(clk), .i_rst(rst), .i_start(start), .i_num(num),
    .o_ref_tick(ref_t), .o_sync_tick(sync_t), .o_vco_tick(vco_t),
    .o_busy(busy)
  );

  // Divided tick counters, cleared in the cycle a burst starts
  always @(posedge clk) begin
    if (start) begin
      n_ref <= 0;
      n_sync <= 0;
      n_out <= 0;
    end else begin
      n_ref <= n_ref + 32'(ref_o);
      n_sync <= n_sync + 32'(sync_o);
      n_out <= n_out + 32'(out_o);
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One transfer; request held until pready is seen high
  task automatic apb(input logic [8:0] idx, input logic w,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ADDR_W'({idx, 2'b00});
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    // Answer taken at the edge that sees pready, released right after
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask

  // Write, then let raw and decoded outputs settle
  task automatic wr(input logic [8:0] idx, input logic [31:0] wd);
    apb(idx, 1'b1, wd);
    repeat (2) @(negedge clk);
  endtask

  task automatic rd(input logic [8:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, '0);
    chk(rdv, exp);
  endtask

  // Fixed bursts from the far side; counters clear on the start cycle
  task automatic burst(input logic [7:0] k);
    int n;
    @(posedge clk);
    start <= 1'b1;
    num <= k;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    repeat (4) @(negedge clk);
    if (busy !== 1'b0) begin
      errors++;
      finish_test();
    end
  endtask

  function automatic logic [31:0] outv(input int sel);
    case (sel)
      0: return 32'(lratio);
      1: return 32'(oratio);
      2: return 32'(rratio);
      3: return 32'(sratio);
      4: return 32'(mult);
      5: return 32'(fnum);
      6: return 32'(fden);
      7: return 32'(sgain);
      8: return 32'(narrow);
      9: return 32'(sint);
      10: return 32'(snum);
      default: return 32'(sden);
    endcase
  endfunction

  initial begin
    // Field codes with their decoded results; reserved bits set high in the outdiv and refdiv rows
    for (int c = 0; c < 16; c++)
      rows.push_back('{IDX_RATIO, 32'(c << 8) | 32'h6,
                       32'(c << 8) | 32'h6, 0, c + 1});
    for (int c = 0; c < 8; c++)
      rows.push_back('{IDX_RATIO, 32'hfffff0f1 | 32'(c << 1),
                       32'(c << 1), 1, (c < 2) ? 0 : c});
    for (int c = 0; c < 4; c++)
      rows.push_back('{IDX_REFDIV, 32'hffffff3f | 32'(c << 6),
                       32'(c << 6), 2, 1 << c});
    for (int c = 0; c < 8; c++)
      rows.push_back('{IDX_SYNC_RATIO, 32'(c << 8), 32'(c << 8), 3,
                       (c > 3) ? 16 : 1 << c});
    rows.push_back('{IDX_INT, 32'h83ff, 32'h3ff, 4, 32'h3ff});
    rows.push_back('{IDX_NUM, 32'h1ffff, 32'hffff, 5, 32'hffff});
    rows.push_back('{IDX_DEN, 32'hffff, 32'hffff, 6, 32'hffff});
    rows.push_back('{IDX_SYNC_GAIN, 32'h10, 32'h10, 7, 32'h4});
    rows.push_back('{IDX_SYNC_GAIN, 32'h1, 32'h1, 8, 32'h1});
    rows.push_back('{IDX_SYNC_INT, 32'h3ff, 32'h3ff, 9, 32'h3ff});
    rows.push_back('{IDX_SYNC_NUM, 32'h10bcd, 32'hbcd, 10, 32'hbcd});
    rows.push_back('{IDX_SYNC_DEN, 32'h10a55, 32'ha55, 11, 32'ha55});
    // Outputs while reset is held
    repeat (4) @(posedge clk);
    chk(32'({mult, fnum}), 32'({10'h008, 16'h0018}));
    chk(32'({loop_en, fden}), 32'h007d);
    chk(32'({lratio, oratio, rratio, sratio, narrow, pready}),
        32'({5'h1, 3'h3, 4'h1, 5'h1, 2'b10}));
    rst <= 1'b0;
    rd(IDX_ENA, 32'h0);
    rd(IDX_INT, 32'h8);
    rd(IDX_NUM, 32'h18);
    rd(IDX_DEN, 32'h7d);
    rd(IDX_RATIO, 32'h6);
    rd(IDX_REFDIV, 32'h0);
    rd(IDX_SYNC_GAIN, 32'h1);
    chk(32'(err), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx, rows[i].rd);
      chk(outv(rows[i].sel), rows[i].exp);
    end
    // Unmapped place: write dropped, read zero with error
    wr(9'h1ff, 32'hffff);
    rd(9'h1ff, 32'h0);
    chk(32'(err), 32'h1);
    // Configure everything before the enable goes last
    wr(IDX_DEN, 32'h7d);
    wr(IDX_NUM, 32'h18);
    wr(IDX_INT, 32'h20);
    wr(IDX_RATIO, 32'ha);
    wr(IDX_REFDIV, 32'hc0);
    wr(IDX_SYNC_DIV, 32'h80);
    wr(IDX_ENA, 32'h1);
    chk(32'(loop_en), 32'h1);
    // Running loop: writes stay pending until the update bit
    wr(IDX_INT, 32'h155);
    wr(IDX_NUM, 32'h42);
    chk(32'({mult, fnum}), 32'({10'h020, 16'h0018}));
    rd(IDX_INT, 32'h155);
    wr(IDX_INT, 32'h8156);
    chk(32'({mult, fnum}), 32'({10'h156, 16'h0042}));
    // Dividers on far-side ticks: ref /8, sync input /4, output /5
    burst(8'd40);
    chk(32'(n_ref), 32'd5);
    chk(32'(n_sync), 32'd10);
    chk(32'(n_out), 32'd8);
    wr(IDX_RATIO, 32'h2);
    burst(8'd20);
    chk(32'(n_out), 32'd0);
    // Synchroniser changed only with the loop off
    wr(IDX_ENA, 32'h0);
    wr(IDX_INT, 32'h2a);
    chk(32'(mult), 32'h2a);
    wr(IDX_SYNC_ENA, 32'h1);
    wr(IDX_DEN, 32'h99);
    chk(32'({sync_en, scaled, fden}), 32'({2'b11, 16'h0}));
    wr(IDX_SYNC_ENA, 32'h0);
    chk(32'({sync_en, scaled, fden}), 32'h0099);
    // Second reset in mid-run clears the enable
    wr(IDX_ENA, 32'h1);
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk(32'({loop_en, mult}), 32'h008);
    @(posedge clk);
    rst <= 1'b0;
    rd(IDX_ENA, 32'h0);
    finish_test();
  end
endmodule
